/* File: hdl/oss_decode.sv */
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module oss_decode
  import oss_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    in_valid,
  input  wire logic                    in_ia32e,
  input  wire logic                    in_prot_mode,
  input  wire logic                    cs_long_flag,
  input  wire logic                    cs_default_size,
  input  wire logic                    has_opsize_prefix,
  input  wire logic                    has_addrsize_prefix,
  input  wire logic                    has_register_extension_prefix,
  input  wire logic [OSS_REX_BITS-1:0] register_extension_prefix,
  input  wire logic                    simd_mandatory_66,
  input  wire logic                    has_seg_override,
  input  wire oss_seg_t                seg_override,
  input  wire oss_ref_t                ref_kind,
  input  wire logic [3:0]              base_reg,
  input  wire logic                    base_valid,
  input  wire logic                    byte_reg_op,
  input  wire logic [3:0]              byte_reg_idx,
  input  wire logic                    is_arith,
  input  wire logic                    is_divide,
  input  wire logic                    has_immediate,
  input  wire logic                    uses_reg_pair,
  input  wire logic                    far_ptr_second,
  input  wire logic                    base_wr_en,
  input  wire logic [2:0]              base_wr_idx,
  input  wire logic [OSS_BASE_W-1:0]   base_wr_data,
  output logic                         out_valid_ff,
  output oss_size_t                    op_size_ff,
  output oss_size_t                    addr_size_ff,
  output oss_seg_t                     seg_sel_ff,
  output logic                         seg_base_used_ff,
  output logic [OSS_BASE_W-1:0]        seg_base_ff,
  output logic                         wide_operand_bit_ff,
  output logic                         byte_reg_illegal_ff,
  output logic                         byte_reg_high_ff,
  output logic                         imm_illegal_ff,
  output logic [3:0]                   pair_high_reg_ff,
  output logic [3:0]                   pair_low_reg_ff,
  output logic [5:0]                   far_ptr_part_bits_ff,
  output logic [5:0]                   far_ptr_part_ofs_ff
);

  // Mode decode
  wire logic mode64 = in_ia32e && cs_long_flag;
  wire logic compat = in_ia32e && !cs_long_flag;
  wire logic wide_operand_bit =
    has_register_extension_prefix &&
    register_extension_prefix[OSS_WIDE_OPERAND_BIT_BIT];
  // Mandatory SIMD 66H is an opcode extension, not a size prefix
  wire logic op66 = has_opsize_prefix && !simd_mandatory_66;
  wire logic dflt32 = in_prot_mode && cs_default_size;

  // Operand size in 64-bit mode, indexed by {wide bit, 66H}
  oss_size_t op64;
  always_comb begin
    op64 = OSS_SZ_32;
    case ({wide_operand_bit, op66})
      2'h0:    op64 = OSS_SZ_32;
      2'h1:    op64 = OSS_SZ_16;
      2'h2:    op64 = OSS_SZ_64;
      2'h3:    op64 = OSS_SZ_64;
      default: op64 = OSS_SZ_32;
    endcase
  end

  // Address size in 64-bit mode: only 64 or 32, never 16
  oss_size_t ad64;
  always_comb begin
    ad64 = OSS_SZ_64;
    case (has_addrsize_prefix)
      1'h0:    ad64 = OSS_SZ_64;
      1'h1:    ad64 = OSS_SZ_32;
      default: ad64 = OSS_SZ_64;
    endcase
  end

  // Legacy and compatibility operand size, indexed by {D flag, 66H}
  oss_size_t op_leg;
  always_comb begin
    op_leg = OSS_SZ_16;
    case ({dflt32, op66})
      2'h0:    op_leg = OSS_SZ_16;
      2'h1:    op_leg = OSS_SZ_32;
      2'h2:    op_leg = OSS_SZ_32;
      2'h3:    op_leg = OSS_SZ_16;
      default: op_leg = OSS_SZ_16;
    endcase
  end

  // Legacy and compatibility address size, indexed by {D flag, 67H}
  oss_size_t ad_leg;
  always_comb begin
    ad_leg = OSS_SZ_16;
    case ({dflt32, has_addrsize_prefix})
      2'h0:    ad_leg = OSS_SZ_16;
      2'h1:    ad_leg = OSS_SZ_32;
      2'h2:    ad_leg = OSS_SZ_32;
      2'h3:    ad_leg = OSS_SZ_16;
      default: ad_leg = OSS_SZ_16;
    endcase
  end

  wire oss_size_t nxt_op_size   = mode64 ? op64 : op_leg;
  wire oss_size_t nxt_addr_size = mode64 ? ad64 : ad_leg;

  // Segment selection
  logic sp_bp_reg;
  always_comb begin
    sp_bp_reg = 1'b0;
    case (base_reg)
      OSS_GPR_SP: sp_bp_reg = 1'b1;
      OSS_GPR_BP: sp_bp_reg = 1'b1;
      default:    sp_bp_reg = 1'b0;
    endcase
  end
  wire logic sp_bp_base = base_valid && sp_bp_reg;

  // Which reference kinds accept an override prefix
  logic ref_overridable;
  always_comb begin
    ref_overridable = 1'b0;
    case (ref_kind)
      OSS_REF_FETCH: ref_overridable = 1'b0;
      OSS_REF_STACK: ref_overridable = 1'b0;
      OSS_REF_STRD:  ref_overridable = 1'b0;
      OSS_REF_DATA:  ref_overridable = 1'b1;
      OSS_REF_FARP:  ref_overridable = 1'b1;
      default:       ref_overridable = 1'b0;
    endcase
  end

  wire oss_seg_t data_default =
    sp_bp_base ? OSS_SEG_STACK : OSS_SEG_DATA;
  wire logic take_override = has_seg_override && ref_overridable;
  wire oss_seg_t data_seg =
    take_override ? seg_override : data_default;

  logic     nxt_base_used;
  oss_seg_t nxt_seg;
  always_comb begin
    nxt_seg = OSS_SEG_DATA;
    case (ref_kind)
      OSS_REF_FETCH: nxt_seg = OSS_SEG_CODE;
      OSS_REF_STACK: nxt_seg = OSS_SEG_STACK;
      OSS_REF_STRD:  nxt_seg = OSS_SEG_EXTRA;
      OSS_REF_DATA:  nxt_seg = data_seg;
      OSS_REF_FARP:  nxt_seg = data_seg;
      default:       nxt_seg = OSS_SEG_DATA;
    endcase
  end

  // Per segment: selected now, and keeps its base in 64-bit mode
  logic [5:0] seg_hot;
  logic [5:0] seg_keeps_base;
  for (genvar s = 0; s < 6; s++) begin : g_seg
    assign seg_hot[s]        = (nxt_seg == oss_seg_t'(s));
    assign seg_keeps_base[s] = (s == int'(OSS_SEG_AUX_A)) ||
                               (s == int'(OSS_SEG_AUX_B));
  end
  wire logic aux_seg  = |(seg_hot & seg_keeps_base);
  wire logic ref_used = (ref_kind != OSS_REF_NONE);

  // Flat segmentation except auxiliary pair; compat as legacy
  wire logic [1:0] mode_sel = {mode64, compat};
  always_comb begin
    nxt_base_used = 1'b0;
    case (mode_sel)
      2'h2:    nxt_base_used = ref_used && aux_seg;
      2'h1:    nxt_base_used = ref_used;
      default: nxt_base_used = ref_used;
    endcase
  end

  // Byte register legality in 64-bit mode
  logic [15:0] byte_hi_map;
  logic [15:0] byte_ext_map;
  for (genvar b = 0; b < 16; b++) begin : g_byte
    assign byte_hi_map[b]  = (b >= 4) && (b < 8);
    assign byte_ext_map[b] = (b >= 8);
  end
  wire logic idx_hi4 = byte_hi_map[byte_reg_idx];
  wire logic idx_ext = byte_ext_map[byte_reg_idx];
  wire logic nxt_byte_high = byte_reg_op && idx_hi4 &&
    !(mode64 && has_register_extension_prefix);
  wire logic nxt_byte_bad = byte_reg_op && idx_ext &&
    !(mode64 && has_register_extension_prefix);

  // Immediate source legal for arithmetic except the divides
  logic nxt_imm_bad;
  always_comb begin
    nxt_imm_bad = 1'b0;
    case ({is_arith, is_divide, has_immediate})
      3'h7:    nxt_imm_bad = 1'b1;
      default: nxt_imm_bad = 1'b0;
    endcase
  end

  // Far pointer part: offset doubleword, then selector word
  logic [5:0] nxt_fp_bits;
  logic [5:0] nxt_fp_ofs;
  always_comb begin
    nxt_fp_bits = 6'h00;
    nxt_fp_ofs  = 6'h00;
    case (far_ptr_second)
      1'h0: begin
        nxt_fp_bits = 6'(OSS_FARP_OFS_BITS);
        nxt_fp_ofs  = 6'h00;
      end
      1'h1: begin
        nxt_fp_bits = 6'(OSS_FARP_SEL_BITS);
        nxt_fp_ofs  = 6'(OSS_FARP_OFS_BITS);
      end
      default: begin
        nxt_fp_bits = 6'h00;
        nxt_fp_ofs  = 6'h00;
      end
    endcase
  end

  // Control sequencing
  oss_state_t state_ff;
  oss_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      OSS_ST_IDLE: nxt_state = in_valid ? OSS_ST_RUN : OSS_ST_IDLE;
      OSS_ST_RUN:  nxt_state = in_valid ? OSS_ST_RUN : OSS_ST_HOLD;
      OSS_ST_HOLD: nxt_state = in_valid ? OSS_ST_RUN : OSS_ST_IDLE;
      default:     nxt_state = OSS_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= OSS_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Base lookup aligned with registered outputs
  oss_seg_base_mem u_base (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .wr_en      (base_wr_en),
    .wr_idx     (base_wr_idx),
    .wr_data    (base_wr_data),
    .rd_idx     (nxt_seg),
    .rd_data_ff (seg_base_ff)
  );

  // Next values of the side outputs
  wire logic       nxt_wide      = wide_operand_bit && mode64;
  wire logic       is_farp       = (ref_kind == OSS_REF_FARP);
  wire logic [3:0] nxt_pair_high = uses_reg_pair ? OSS_GPR_DX : 4'h0;
  wire logic [5:0] nxt_fp_part   = is_farp ? nxt_fp_bits : 6'h00;
  wire logic [5:0] nxt_fp_start  = is_farp ? nxt_fp_ofs : 6'h00;

  // Instruction valid
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
    end else begin
      out_valid_ff <= in_valid;
    end
  end

  // Sizes, registered with the instruction
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      op_size_ff   <= oss_size_t'(OSS_SZ_RST);
      addr_size_ff <= oss_size_t'(OSS_SZ_RST);
    end else begin
      op_size_ff   <= nxt_op_size;
      addr_size_ff <= nxt_addr_size;
    end
  end

  // Segment choice, same cycle as the base lookup
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seg_sel_ff       <= oss_seg_t'(OSS_SEG_RST);
      seg_base_used_ff <= 1'b0;
    end else begin
      seg_sel_ff       <= nxt_seg;
      seg_base_used_ff <= nxt_base_used;
    end
  end

  // Register and prefix checks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wide_operand_bit_ff <= 1'b0;
      byte_reg_illegal_ff <= 1'b0;
      byte_reg_high_ff    <= 1'b0;
      imm_illegal_ff      <= 1'b0;
    end else begin
      wide_operand_bit_ff <= nxt_wide;
      byte_reg_illegal_ff <= nxt_byte_bad;
      byte_reg_high_ff    <= nxt_byte_high;
      imm_illegal_ff      <= nxt_imm_bad;
    end
  end

  // Register pair
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pair_high_reg_ff <= OSS_GPR_DX;
      pair_low_reg_ff  <= OSS_GPR_AX;
    end else begin
      pair_high_reg_ff <= nxt_pair_high;
      pair_low_reg_ff  <= OSS_GPR_AX;
    end
  end

  // Far pointer part
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      far_ptr_part_bits_ff <= 6'h00;
      far_ptr_part_ofs_ff  <= 6'h00;
    end else begin
      far_ptr_part_bits_ff <= nxt_fp_part;
      far_ptr_part_ofs_ff  <= nxt_fp_start;
    end
  end

endmodule // oss_decode

/* File: hdl/oss_pkg.sv */
package oss_pkg;

  // Effective size encodings
  typedef enum logic [1:0] {
    OSS_SZ_16 = 2'h0,
    OSS_SZ_32 = 2'h1,
    OSS_SZ_64 = 2'h2
  } oss_size_t;

  // Segment register indices
  typedef enum logic [2:0] {
    OSS_SEG_EXTRA = 3'h0,
    OSS_SEG_CODE  = 3'h1,
    OSS_SEG_STACK = 3'h2,
    OSS_SEG_DATA  = 3'h3,
    OSS_SEG_AUX_A = 3'h4,
    OSS_SEG_AUX_B = 3'h5
  } oss_seg_t;

  // Kind of memory reference
  typedef enum logic [2:0] {
    OSS_REF_NONE  = 3'h0,
    OSS_REF_FETCH = 3'h1,
    OSS_REF_STACK = 3'h2,
    OSS_REF_DATA  = 3'h3,
    OSS_REF_STRD  = 3'h4,
    OSS_REF_FARP  = 3'h5
  } oss_ref_t;

  // Decode pipeline state
  typedef enum logic [1:0] {
    OSS_ST_IDLE = 2'h0,
    OSS_ST_RUN  = 2'h1,
    OSS_ST_HOLD = 2'h3
  } oss_state_t;

  localparam int           OSS_WIDE_OPERAND_BIT_BIT      = 3;
  localparam int           OSS_REX_BITS       = 4;
  localparam int           OSS_BASE_W         = 64;
  localparam int           OSS_FARP_BITS      = 48;
  localparam int           OSS_FARP_OFS_BITS  = 32;
  localparam int           OSS_FARP_SEL_BITS  = 16;
  localparam logic [3:0]   OSS_GPR_SP         = 4'h4;
  localparam logic [3:0]   OSS_GPR_BP         = 4'h5;
  localparam logic [3:0]   OSS_GPR_AX         = 4'h0;
  localparam logic [3:0]   OSS_GPR_DX         = 4'h2;
  localparam logic [2:0]   OSS_SEG_RST        = 3'h3;
  localparam logic [1:0]   OSS_SZ_RST         = 2'h0;
  localparam logic [2:0]   OSS_NUM_SEGS       = 3'h6;

endpackage

/* File: hdl/oss_seg_base_mem.sv */
`timescale 1ns/1ps
// Six segment base words, registered read port
module oss_seg_base_mem
  import oss_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  wr_en,
  input  wire logic [2:0]            wr_idx,
  input  wire logic [OSS_BASE_W-1:0] wr_data,
  input  wire logic [2:0]            rd_idx,
  output logic      [OSS_BASE_W-1:0] rd_data_ff
);

  logic [OSS_BASE_W-1:0] mem_ff [6];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (wr_en && (wr_idx < OSS_NUM_SEGS)) begin
      mem_ff[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data_ff <= '0;
    end else if (rd_idx < OSS_NUM_SEGS) begin
      rd_data_ff <= mem_ff[rd_idx];
    end else begin
      rd_data_ff <= '0;
    end
  end

endmodule // oss_seg_base_mem

/* File: dv/oss_decode_props.sv */
`timescale 1ns/1ps
module oss_decode_props
  import oss_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      rst_n,
  input wire logic      in_valid,
  input wire logic      in_ia32e,
  input wire logic      cs_long_flag,
  input wire logic      has_opsize_prefix,
  input wire logic      has_addrsize_prefix,
  input wire logic      has_register_extension_prefix,
  input wire logic [3:0] register_extension_prefix,
  input wire logic      simd_mandatory_66,
  input wire oss_ref_t  ref_kind,
  input wire logic      is_divide,
  input wire logic      has_immediate,
  input wire logic      out_valid_ff,
  input wire oss_size_t op_size_ff,
  input wire oss_size_t addr_size_ff,
  input wire oss_seg_t  seg_sel_ff,
  input wire logic      seg_base_used_ff,
  input wire logic      wide_operand_bit_ff,
  input wire logic      imm_illegal_ff
);
  logic m64_ff;
  wire  m64 = in_ia32e && cs_long_flag;
  wire  wide = has_register_extension_prefix && register_extension_prefix[3];
  always_ff @(posedge ref_clk) m64_ff <= m64;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_NO16: assert property (in_valid && m64 |=>
    addr_size_ff != OSS_SZ_16) else $error("16-bit address in 64-bit mode");
  AST_A64: assert property (in_valid && m64 && !has_addrsize_prefix |=>
    addr_size_ff == OSS_SZ_64) else $error("address size not 64");
  AST_WIDE: assert property (in_valid && m64 && wide |=>
    op_size_ff == OSS_SZ_64 && wide_operand_bit_ff) else $error("wide lost");
  AST_OP16: assert property (in_valid && m64 && !wide &&
    has_opsize_prefix && !simd_mandatory_66 |=> op_size_ff == OSS_SZ_16)
    else $error("operand size not 16");
  AST_FETCH: assert property (in_valid && ref_kind == OSS_REF_FETCH |=>
    seg_sel_ff == OSS_SEG_CODE) else $error("fetch not from code");
  AST_STRD: assert property (in_valid && ref_kind == OSS_REF_STRD |=>
    seg_sel_ff == OSS_SEG_EXTRA) else $error("string dest not extra");
  AST_FLAT: assert property (out_valid_ff && m64_ff && seg_sel_ff inside
    {OSS_SEG_CODE, OSS_SEG_DATA, OSS_SEG_EXTRA, OSS_SEG_STACK}
    |-> !seg_base_used_ff) else $error("flat segment base used");
  AST_DIV: assert property (in_valid && is_divide && has_immediate |=>
    imm_illegal_ff) else $error("divide immediate accepted");
endmodule // oss_decode_props

bind oss_decode oss_decode_props chk_u (.*);

/* File: dv/oss_agen_model.sv */
`timescale 1ns/1ps
module oss_agen_model
  import oss_pkg::*;
(
  input  wire logic                  base_used,
  input  wire logic [OSS_BASE_W-1:0] base,
  input  wire logic [OSS_BASE_W-1:0] eff_addr,
  output logic      [OSS_BASE_W-1:0] lin_addr
);
  // Flat segments add nothing, auxiliary bases add an extra term
  assign lin_addr = base_used ? base + eff_addr : eff_addr;
endmodule // oss_agen_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", n, e, a); end end
module tb_top;
  import oss_pkg::*;
  logic ref_clk = 0, rst_n = 0, in_valid = 0, in_ia32e = 0, in_prot_mode = 0;
  logic cs_long_flag = 0, cs_default_size = 0, has_opsize_prefix = 0;
  logic has_addrsize_prefix = 0, has_register_extension_prefix = 0;
  logic simd_mandatory_66 = 0, has_seg_override = 0, base_valid = 0;
  logic byte_reg_op = 0, is_arith = 0, is_divide = 0, has_immediate = 0;
  logic uses_reg_pair = 0, far_ptr_second = 0, base_wr_en = 0, p;
  logic [3:0] register_extension_prefix = 4'h0, base_reg = 4'h0;
  logic [3:0] byte_reg_idx = 4'h0, pair_high_reg_ff, pair_low_reg_ff;
  logic [2:0] base_wr_idx = 3'h0;
  logic [63:0] base_wr_data = 64'h0, ea = 64'h1000, lin_addr, seg_base_ff;
  oss_seg_t seg_override = OSS_SEG_DATA, seg_sel_ff;
  oss_ref_t ref_kind = OSS_REF_NONE;
  logic out_valid_ff, seg_base_used_ff, wide_operand_bit_ff;
  logic byte_reg_illegal_ff, byte_reg_high_ff, imm_illegal_ff;
  oss_size_t op_size_ff, addr_size_ff, eo, ez;
  logic [5:0] far_ptr_part_bits_ff, far_ptr_part_ofs_ff;
  int fails = 0, checks = 0, cyc = 0;

  oss_decode dut_u (.*);
  oss_agen_model agen_u (.base_used(seg_base_used_ff), .base(seg_base_ff),
                         .eff_addr(ea), .lin_addr(lin_addr));

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 1000) begin
      fails++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task dec(input int m, input logic d, input oss_ref_t rk);
    @(posedge ref_clk);
    in_valid <= 1;
    in_prot_mode <= 1;
    in_ia32e <= (m != 0);
    cs_long_flag <= (m == 2);
    cs_default_size <= d;
    ref_kind <= rk;
    @(posedge ref_clk);
    #1;
  endtask

  task seg(input int m, input oss_ref_t rk, input logic bv, input logic [3:0] br,
           input logic ho, input oss_seg_t os, input oss_seg_t ex);
    base_valid <= bv;
    base_reg <= br;
    has_seg_override <= ho;
    seg_override <= os;
    dec(m, 1, rk);
    `CHK("segment", ex, seg_sel_ff)
  endtask

  task wbase(input logic [2:0] idx, input logic [63:0] v);
    @(posedge ref_clk);
    base_wr_en <= 1;
    base_wr_idx <= idx;
    base_wr_data <= v;
    @(posedge ref_clk);
    base_wr_en <= 0;
  endtask

  task byt(input logic rx, input logic [3:0] idx, input logic hi, input logic il);
    byte_reg_op <= 1;
    has_register_extension_prefix <= rx;
    register_extension_prefix <= 4'h0;
    byte_reg_idx <= idx;
    dec(2, 1, OSS_REF_NONE);
    `CHK("high byte", hi, byte_reg_high_ff)
    `CHK("byte illegal", il, byte_reg_illegal_ff)
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    #1;
    `CHK("reset segment", OSS_SEG_DATA, seg_sel_ff)
    `CHK("reset pair", 4'h2, pair_high_reg_ff)
    for (int m = 0; m < 3; m++) begin
      for (int i = 0; i < 32; i++) begin
        has_opsize_prefix <= i[0];
        has_addrsize_prefix <= i[1];
        register_extension_prefix <= {i[2], 3'h5};
        has_register_extension_prefix <= i[2] | i[3];
        simd_mandatory_66 <= i[4];
        dec(m, i[3], OSS_REF_DATA);
        p = i[0] & ~i[4];
        if (m == 2) eo = i[2] ? OSS_SZ_64 : p ? OSS_SZ_16 : OSS_SZ_32;
        else eo = (i[3] ^ p) ? OSS_SZ_32 : OSS_SZ_16;
        if (m == 2) ez = i[1] ? OSS_SZ_32 : OSS_SZ_64;
        else ez = (i[3] ^ i[1]) ? OSS_SZ_32 : OSS_SZ_16;
        `CHK("op size", eo, op_size_ff)
        `CHK("addr size", ez, addr_size_ff)
        `CHK("wide", i[2] && m == 2, wide_operand_bit_ff)
      end
    end
    seg(2, OSS_REF_FETCH, 0, 4'h0, 1, OSS_SEG_AUX_A, OSS_SEG_CODE);
    seg(2, OSS_REF_STACK, 0, 4'h0, 1, OSS_SEG_DATA, OSS_SEG_STACK);
    seg(2, OSS_REF_DATA, 1, OSS_GPR_SP, 0, OSS_SEG_DATA, OSS_SEG_STACK);
    seg(2, OSS_REF_DATA, 1, OSS_GPR_BP, 0, OSS_SEG_DATA, OSS_SEG_STACK);
    seg(2, OSS_REF_DATA, 1, 4'h3, 0, OSS_SEG_AUX_A, OSS_SEG_DATA);
    seg(2, OSS_REF_STRD, 0, 4'h0, 1, OSS_SEG_AUX_B, OSS_SEG_EXTRA);
    seg(2, OSS_REF_DATA, 0, 4'h0, 1, OSS_SEG_AUX_B, OSS_SEG_AUX_B);
    wbase(3'h4, 64'hA5A50000);
    wbase(3'h3, 64'h7700);
    seg(2, OSS_REF_DATA, 0, 4'h0, 1, OSS_SEG_AUX_A, OSS_SEG_AUX_A);
    `CHK("aux linear", 64'hA5A51000, lin_addr)
    seg(2, OSS_REF_DATA, 0, 4'h0, 0, OSS_SEG_AUX_A, OSS_SEG_DATA);
    `CHK("flat linear", ea, lin_addr)
    seg(1, OSS_REF_DATA, 0, 4'h0, 0, OSS_SEG_AUX_A, OSS_SEG_DATA);
    `CHK("compat linear", 64'h8700, lin_addr)
    byt(1, 4'h6, 0, 0);
    byt(0, 4'h6, 1, 0);
    byt(0, 4'h9, 0, 1);
    for (int f = 0; f < 2; f++) begin
      is_arith <= 1;
      has_immediate <= 1;
      is_divide <= f[0];
      uses_reg_pair <= 1;
      far_ptr_second <= f[0];
      dec(2, 1, OSS_REF_FARP);
      `CHK("imm illegal", f[0], imm_illegal_ff)
      `CHK("pair high", 4'h2, pair_high_reg_ff)
      `CHK("pair low", 4'h0, pair_low_reg_ff)
      `CHK("far bits", f[0] ? 6'h10 : 6'h20, far_ptr_part_bits_ff)
      `CHK("far ofs", f[0] ? 6'h20 : 6'h00, far_ptr_part_ofs_ff)
    end
    end_of_test();
  end
endmodule // tb_top
